// *** logic/stc_hyst.sv ***
// Two-threshold switch with hysteresis for one subsystem
`timescale 1ns/1ns
module stc_hyst #(
    parameter bit HOT = 1'b1,
    parameter bit OFF_INCL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    stc_hyst_if.core hif
);
    logic state_reg;
    logic state_next;

    // Hot channels: any sensor above on, all below off (at or below with OFF_INCL); cold channels: any sensor below on, any sensor above off
    always_comb begin
        state_next = state_reg;
        if (HOT) begin
            if (!state_reg && hif.t_max > hif.on_thr) begin
                state_next = 1'b1;
            end else if (state_reg && (OFF_INCL ? hif.t_max <= hif.off_thr
                                                : hif.t_max < hif.off_thr)) begin
                state_next = 1'b0;
            end
        end else begin
            if (!state_reg && hif.t_min < hif.on_thr) begin
                state_next = 1'b1;
            end else if (state_reg && hif.t_max > hif.off_thr) begin
                state_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hif.state = state_reg;
    assign hif.rise = !state_reg && state_next;
    assign hif.fall = state_reg && !state_next;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    hot_switch_on_a: assert property (HOT && !state_reg && hif.t_max > hif.on_thr |=> state_reg)
        else $error("hot channel did not switch on above threshold");
    band_hold_a: assert property (
        HOT && hif.t_max <= hif.on_thr && hif.t_max > hif.off_thr |=> $stable(state_reg))
        else $error("state changed inside the hysteresis band");
endmodule

// *** logic/stc_hyst_if.sv ***
// Signals between the supervisor and one hysteresis channel
`timescale 1ns/1ns
interface stc_hyst_if #(parameter int TW = 10);
    logic signed [TW-1:0] t_max;
    logic signed [TW-1:0] t_min;
    logic signed [TW-1:0] on_thr;
    logic signed [TW-1:0] off_thr;
    logic state;
    logic rise;
    logic fall;
    modport core (input t_max, t_min, on_thr, off_thr, output state, rise, fall);
    modport ctl (output t_max, t_min, on_thr, off_thr, input state, rise, fall);
endinterface

// *** logic/stc_pkg.sv ***
// Shared constants for the sign thermal supervisor
package stc_pkg;
    localparam int TW = 10;
    localparam int NCH = 4;
    localparam int TIMER_W = 16;
    localparam int ST_W = 5;

    // Temperatures are signed whole degrees Fahrenheit
    localparam logic signed [TW-1:0] TEMP_MIN = 10'sh3d8;
    localparam logic signed [TW-1:0] TEMP_MAX = 10'sh0b9;

    // Channel order
    localparam int CH_SHUT = 0;
    localparam int CH_HOUSE = 1;
    localparam int CH_DISP = 2;
    localparam int CH_DEFOG = 3;

    // Reset values of the thresholds, channel 0 in the low bits
    localparam logic [NCH*TW-1:0] ON_DEF = {10'h028, 10'h05a, 10'h05a, 10'h08c};
    localparam logic [NCH*TW-1:0] OFF_DEF = {10'h06a, 10'h055, 10'h055, 10'h082};
    localparam logic [NCH-1:0] HOT_MASK = 4'h7;
    localparam logic [NCH-1:0] OFF_INCL_MASK = 4'h4;

    // Housing fan-off timer in seconds; zero disables it
    localparam logic [TIMER_W-1:0] FAN_TIMER_DEF = 16'h3840;
    localparam int TICK_S = 1;
    localparam int CLK_HZ = 125000000;
    localparam int SEC_CYCLES_DEF = CLK_HZ * TICK_S;

    // Byte addresses
    localparam logic [5:0] A_STATUS = 6'h00;
    localparam logic [5:0] A_MASK = 6'h04;
    localparam logic [5:0] A_STATE = 6'h08;
    localparam logic [5:0] A_TEMP = 6'h0c;
    localparam logic [5:0] A_THR_BASE = 6'h10;
    localparam logic [5:0] A_THR_END = 6'h2c;
    localparam logic [5:0] A_TIMER = 6'h30;
    localparam logic [5:0] A_HEAT = 6'h34;

    // Status and mask bits
    localparam int ST_SHUT = 0;
    localparam int ST_RESTART = 1;
    localparam int ST_PFAIL = 2;
    localparam int ST_RANGE = 3;
    localparam int ST_TIMER = 4;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } stc_bus_type;
endpackage

// *** logic/stc_top.sv ***
// Thermal supervisor: display shutdown, fans, heaters, power fail, Avalon registers
`timescale 1ns/1ns
// What this block does
// - Sample both board temperature sensors every clock and drive all decisions from them.
// - Accept readings from -40 to +185 F; clamp and flag anything outside.
// - Blank the display when either sensor exceeds the shutdown limit, default 140 F.
// - Restore the display once temperature falls below the restart limit, default 130 F.
// - Shutdown and restart limits are software-writable registers.
// - Report temperatures and every shutdown and restart event to software.
// - Housing, display and defog thresholds are software-writable registers.
// - Housing fans on above 90 F, off below 85 F by default.
// - Housing fans stop when an adjustable timer, four hours by default, expires.
// - Display fans on above 90 F, off at 85 F or lower by default.
// - Defog fans on below 40 F, off above 106 F by default.
// - Heaters may run only while defog fans run.
// - Detect loss of sign supply power and report it to software.
module stc_top import stc_pkg::*; #(
    parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic signed [TW-1:0] i_temp_a,
    input wire logic signed [TW-1:0] i_temp_b,
    input wire logic i_power_ok,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_irq,
    output logic o_display_on,
    output logic o_housing_fan,
    output logic o_display_fan,
    output logic o_defog_fan,
    output logic o_heater
);
    localparam int SW = $clog2(SEC_CYCLES);

    function automatic logic signed [TW-1:0] clamp_t(input logic signed [TW-1:0] t);
        if (t < TEMP_MIN) begin
            return TEMP_MIN;
        end
        if (t > TEMP_MAX) begin
            return TEMP_MAX;
        end
        return t;
    endfunction

    logic signed [TW-1:0] temp_a_reg, temp_a_next, temp_b_reg, temp_b_next;
    logic [NCH-1:0][TW-1:0] on_thr_reg, on_thr_next, off_thr_reg, off_thr_next;
    logic [ST_W-1:0] status_reg, status_next, mask_reg, mask_next, ev;
    logic [TIMER_W-1:0] timer_set_reg, timer_set_next, timer_cnt_reg, timer_cnt_next;
    logic [SW-1:0] sec_cnt_reg, sec_cnt_next;
    logic timer_exp_reg, timer_exp_next, heat_en_reg, heat_en_next;
    logic pwr_ok_reg, pwr_ok_next;
    logic [31:0] rdata_reg, rdata_next, rmux, wmask, wval;
    stc_bus_type bus_reg, bus_next;
    logic req, acc, sec_tick, raw_range_bad;
    logic [NCH-1:0] ch_state, ch_rise, ch_fall;
    logic [3:0] thr_idx;

    // Sampling and clamping
    assign raw_range_bad = (i_temp_a < TEMP_MIN) || (i_temp_a > TEMP_MAX)
                        || (i_temp_b < TEMP_MIN) || (i_temp_b > TEMP_MAX);
    always_comb begin
        temp_a_next = clamp_t(i_temp_a);
        temp_b_next = clamp_t(i_temp_b);
    end

    // One channel per subsystem
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            stc_hyst_if #(.TW(TW)) hif ();
            assign hif.t_max = (temp_a_reg > temp_b_reg) ? temp_a_reg : temp_b_reg;
            assign hif.t_min = (temp_a_reg < temp_b_reg) ? temp_a_reg : temp_b_reg;
            assign hif.on_thr = on_thr_reg[g];
            assign hif.off_thr = off_thr_reg[g];
            assign ch_state[g] = hif.state;
            assign ch_rise[g] = hif.rise;
            assign ch_fall[g] = hif.fall;
            stc_hyst #(.HOT(HOT_MASK[g]), .OFF_INCL(OFF_INCL_MASK[g])) u_hyst (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .hif(hif)
            );
        end
    endgenerate

    // Bus: one wait cycle per access, so read data come from a register
    assign req = i_avs_read || i_avs_write;
    assign acc = req && (bus_reg == BUS_DONE);
    assign o_avs_waitrequest = req && (bus_reg == BUS_IDLE);
    assign o_avs_readdata = rdata_reg;
    assign thr_idx = 4'((i_avs_address - A_THR_BASE) >> 2);
    assign wmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                    {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    always_comb begin
        bus_next = bus_reg;
        unique case (bus_reg)
            BUS_IDLE: begin
                if (req) begin
                    bus_next = BUS_DONE;
                end
            end
            BUS_DONE: begin
                bus_next = BUS_IDLE;
            end
            default: begin
                bus_next = BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        rmux = 32'h0000_0000;
        if (i_avs_address == A_STATUS) begin
            rmux = 32'(status_reg);
        end else if (i_avs_address == A_MASK) begin
            rmux = 32'(mask_reg);
        end else if (i_avs_address == A_STATE) begin
            rmux = 32'({o_heater, o_defog_fan, o_display_fan, o_housing_fan,
                        o_display_on, pwr_ok_reg, timer_exp_reg});
        end else if (i_avs_address == A_TEMP) begin
            rmux = {16'(temp_b_reg), 16'(temp_a_reg)};
        end else if (i_avs_address >= A_THR_BASE && i_avs_address <= A_THR_END
                     && i_avs_address[1:0] == 2'h0) begin
            rmux = thr_idx[0] ? 32'(signed'(off_thr_reg[thr_idx[3:1]]))
                              : 32'(signed'(on_thr_reg[thr_idx[3:1]]));
        end else if (i_avs_address == A_TIMER) begin
            rmux = 32'(timer_set_reg);
        end else if (i_avs_address == A_HEAT) begin
            rmux = 32'(heat_en_reg);
        end
        rdata_next = rdata_reg;
        if (i_avs_read && bus_reg == BUS_IDLE) begin
            rdata_next = rmux;
        end
    end

    // Register writes; software settings steer all thresholds and the timer
    always_comb begin
        wval = (rmux & ~wmask) | (i_avs_writedata & wmask);
        on_thr_next = on_thr_reg;
        off_thr_next = off_thr_reg;
        mask_next = mask_reg;
        timer_set_next = timer_set_reg;
        heat_en_next = heat_en_reg;
        if (acc && i_avs_write) begin
            if (i_avs_address == A_MASK) begin
                mask_next = wval[ST_W-1:0];
            end else if (i_avs_address == A_TIMER) begin
                timer_set_next = wval[TIMER_W-1:0];
            end else if (i_avs_address == A_HEAT) begin
                heat_en_next = wval[0];
            end else if (i_avs_address >= A_THR_BASE && i_avs_address <= A_THR_END
                         && i_avs_address[1:0] == 2'h0) begin
                if (thr_idx[0]) begin
                    off_thr_next[thr_idx[3:1]] = wval[TW-1:0];
                end else begin
                    on_thr_next[thr_idx[3:1]] = wval[TW-1:0];
                end
            end
        end
    end

    // Housing fan timer, counted in one-second ticks
    assign sec_tick = (sec_cnt_reg == SW'(SEC_CYCLES - 1));
    always_comb begin
        sec_cnt_next = sec_tick ? '0 : sec_cnt_reg + 1'b1;
        timer_cnt_next = timer_cnt_reg;
        timer_exp_next = timer_exp_reg;
        if (!ch_state[CH_HOUSE]) begin
            timer_cnt_next = '0;
            timer_exp_next = 1'b0;
        end else if (sec_tick && !timer_exp_reg) begin
            timer_cnt_next = timer_cnt_reg + 1'b1;
            // A zero setting leaves the fans under thermostat control only
            if (timer_set_reg != '0 && timer_cnt_next >= timer_set_reg) begin
                timer_exp_next = 1'b1;
            end
        end
    end

    // Events; a new event wins over the read that clears its bit
    always_comb begin
        ev = '0;
        ev[ST_SHUT] = ch_rise[CH_SHUT];
        ev[ST_RESTART] = ch_fall[CH_SHUT];
        ev[ST_PFAIL] = pwr_ok_reg && !i_power_ok;
        ev[ST_RANGE] = raw_range_bad;
        ev[ST_TIMER] = !timer_exp_reg && timer_exp_next;
        pwr_ok_next = i_power_ok;
        status_next = status_reg;
        // Only bits that were captured into the read data are cleared
        if (acc && i_avs_read && i_avs_address == A_STATUS) begin
            status_next = status_reg & ~rdata_reg[ST_W-1:0];
        end
        status_next = status_next | ev;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            temp_a_reg <= '0;
            temp_b_reg <= '0;
            on_thr_reg <= ON_DEF;
            off_thr_reg <= OFF_DEF;
            status_reg <= '0;
            mask_reg <= '0;
            timer_set_reg <= FAN_TIMER_DEF;
            timer_cnt_reg <= '0;
            timer_exp_reg <= 1'b0;
            sec_cnt_reg <= '0;
            heat_en_reg <= 1'b1;
            pwr_ok_reg <= 1'b1;
            rdata_reg <= 32'h0000_0000;
            bus_reg <= BUS_IDLE;
        end else begin
            temp_a_reg <= temp_a_next;
            temp_b_reg <= temp_b_next;
            on_thr_reg <= on_thr_next;
            off_thr_reg <= off_thr_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            timer_set_reg <= timer_set_next;
            timer_cnt_reg <= timer_cnt_next;
            timer_exp_reg <= timer_exp_next;
            sec_cnt_reg <= sec_cnt_next;
            heat_en_reg <= heat_en_next;
            pwr_ok_reg <= pwr_ok_next;
            rdata_reg <= rdata_next;
            bus_reg <= bus_next;
        end
    end

    assign o_irq = |(status_reg & mask_reg);
    assign o_display_on = !ch_state[CH_SHUT];
    assign o_housing_fan = ch_state[CH_HOUSE] && !timer_exp_reg;
    assign o_display_fan = ch_state[CH_DISP];
    assign o_defog_fan = ch_state[CH_DEFOG];
    assign o_heater = ch_state[CH_DEFOG] && heat_en_reg;

    // Hottest and coldest sample, as the hot and cold channels see them
    logic signed [TW-1:0] t_hi;
    logic signed [TW-1:0] t_lo;
    assign t_hi = (temp_a_reg > temp_b_reg) ? temp_a_reg : temp_b_reg;
    assign t_lo = (temp_a_reg < temp_b_reg) ? temp_a_reg : temp_b_reg;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    heater_needs_fan_a: assert property (o_heater |-> o_defog_fan)
        else $error("heater on while defog fans off");
    sample_clamp_a: assert property (
        ##1 temp_a_reg == clamp_t($past(i_temp_a)) && temp_a_reg >= TEMP_MIN)
        else $error("sensor sample not taken or not clamped");
    range_flag_a: assert property (raw_range_bad |=> status_reg[ST_RANGE])
        else $error("out of range reading not flagged");
    shut_event_a: assert property ($fell(o_display_on) |-> status_reg[ST_SHUT])
        else $error("shutdown without event");
    restart_event_a: assert property ($rose(o_display_on) |-> status_reg[ST_RESTART])
        else $error("restart without event");
    power_fail_a: assert property ($fell(i_power_ok) |=> status_reg[ST_PFAIL])
        else $error("power loss not reported");
    timer_stop_a: assert property (
        $rose(timer_exp_reg) |-> !o_housing_fan && timer_set_reg != '0
        && timer_cnt_reg >= timer_set_reg)
        else $error("housing timer expired early or while disabled");
    shut_limit_write_a: assert property (
        acc && i_avs_write && i_avs_address == A_THR_BASE && i_avs_byteenable == 4'hf
        |=> on_thr_reg[CH_SHUT] == $past(i_avs_writedata[TW-1:0]))
        else $error("shutdown limit not written");
    one_wait_a: assert property (o_avs_waitrequest |=> req && !o_avs_waitrequest)
        else $error("access not answered after one wait cycle");
    display_restart_a: assert property (
        !o_display_on && t_hi < signed'(off_thr_reg[CH_SHUT]) |=> o_display_on)
        else $error("display not restored below restart limit");
    // The display fans stop at the off threshold itself, unlike the housing fans
    disp_fan_off_a: assert property (
        o_display_fan && t_hi <= signed'(off_thr_reg[CH_DISP]) |=> !o_display_fan)
        else $error("display fans still on at off threshold");
    // Cold channel: the coldest sensor starts it, the hottest stops it
    defog_on_a: assert property (
        !o_defog_fan && t_lo < signed'(on_thr_reg[CH_DEFOG]) |=> o_defog_fan)
        else $error("defog fans not started below on threshold");
    defog_off_a: assert property (
        o_defog_fan && t_hi > signed'(off_thr_reg[CH_DEFOG]) |=> !o_defog_fan)
        else $error("defog fans not stopped above off threshold");
    // Bits seen by a status read are gone afterwards unless a new event lands
    status_clear_a: assert property (
        acc && i_avs_read && i_avs_address == A_STATUS && ev == '0
        |=> (status_reg & $past(rdata_reg[ST_W-1:0])) == '0)
        else $error("status bits not cleared by read");

    shutdown_c: cover property ($fell(o_display_on) ##[1:1000] $rose(o_display_on));
    heater_c: cover property (o_heater);
    timer_c: cover property ($rose(timer_exp_reg));
    irq_c: cover property ($rose(o_irq));
    pfail_c: cover property ($fell(i_power_ok) ##1 status_reg[ST_PFAIL]);
endmodule

// *** tb/stc_host.sv ***
// Avalon-MM master standing in for the remote sign control software
`timescale 1ns/1ns
module stc_host (
    input wire logic i_clk,
    input wire logic i_waitrequest,
    input wire logic [31:0] i_readdata,
    output logic [5:0] o_address,
    output logic o_read,
    output logic o_write,
    output logic [31:0] o_writedata,
    output logic [3:0] o_byteenable
);
    // Byte lanes of the next access; the bench narrows it for lane tests
    logic [3:0] be_sel = 4'hf;

    initial begin
        o_address = 6'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'hf;
    end

    // Request held whole until waitrequest is seen low at a rising edge
    task automatic access(input logic rd, input logic [5:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge i_clk);
        o_address <= a;
        o_writedata <= d;
        o_byteenable <= be_sel;
        o_read <= rd;
        o_write <= ~rd;
        do @(posedge i_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench: thermal supervisor against a behavioural model
`timescale 1ns/1ns
`define stc_check(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench import stc_pkg::*; ();
    localparam int SEC = 10;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic pwr = 1'b1;
    logic signed [TW-1:0] ta = '0;
    logic signed [TW-1:0] tb = '0;
    logic [5:0] addr;
    logic rd, wr, wreq, irq, disp, hfan, dfan, ffan, heat;
    logic [31:0] wdat, rdat, q;
    logic [3:0] be;
    int bad_count = 0;
    int num_checks = 0;
    int a;
    int th[8] = '{140, 130, 90, 85, 90, 85, 40, 106};
    int disp_m = 1, house_m = 0, dfan_m = 0, fog_m = 0, hen_m = 1, texp_m = 0;
    int st_m = 0, mask_m = 0;

    stc_top #(.SEC_CYCLES(SEC)) stc_top_inst (.i_clk(clk), .i_rstn(rstn), .i_temp_a(ta),
        .i_temp_b(tb), .i_power_ok(pwr), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_irq(irq), .o_display_on(disp),
        .o_housing_fan(hfan), .o_display_fan(dfan), .o_defog_fan(ffan), .o_heater(heat));
    stc_host stc_host_inst (.i_clk(clk), .i_waitrequest(wreq), .i_readdata(rdat),
        .o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdat), .o_byteenable(be));

    task automatic rw(input logic [5:0] ad, input logic [31:0] d);
        stc_host_inst.access(1'b0, ad, d, q);
    endtask

    task automatic rchk(input string nm, input logic [5:0] ad, input logic [31:0] e);
        stc_host_inst.access(1'b1, ad, 32'h0, q);
        `stc_check(nm, e, q)
    endtask

    task automatic stchk();
        rchk("status", A_STATUS, st_m);
        st_m = 0;
    endtask

    task automatic thr(input int i, input int v);
        th[i] = v;
        rw(A_THR_BASE + 6'(4 * i), 32'(v));
    endtask

    function automatic int clampt(int v);
        return v < -40 ? -40 : (v > 185 ? 185 : v);
    endfunction

    function automatic logic [31:0] state_m();
        return {25'h0, fog_m[0] & hen_m[0], fog_m[0], dfan_m[0], house_m[0] & ~texp_m[0],
            disp_m[0], pwr, texp_m[0]};
    endfunction

    // Drive both sensors, let sample and state registers settle, then compare
    task automatic step(input int ra, input int rb);
        int mx, mn;
        ta <= ra[TW-1:0];
        tb <= rb[TW-1:0];
        repeat (3) @(posedge clk);
        if (ra != clampt(ra) || rb != clampt(rb)) st_m |= 8;
        ra = clampt(ra);
        rb = clampt(rb);
        mx = ra > rb ? ra : rb;
        mn = ra < rb ? ra : rb;
        if (mx > th[0] && disp_m == 1) begin
            disp_m = 0;
            st_m |= 1;
        end else if (mx < th[1] && disp_m == 0) begin
            disp_m = 1;
            st_m |= 2;
        end
        if (mx > th[2]) house_m = 1;
        else if (mx < th[3]) house_m = 0;
        if (house_m == 0) texp_m = 0;
        if (mx > th[4]) dfan_m = 1;
        else if (mx <= th[5]) dfan_m = 0;
        if (mn < th[6]) fog_m = 1;
        else if (mx > th[7]) fog_m = 0;
        `stc_check("display", disp_m[0], disp)
        `stc_check("housing fan", house_m[0] & ~texp_m[0], hfan)
        `stc_check("display fan", dfan_m[0], dfan)
        `stc_check("defog fan", fog_m[0], ffan)
        `stc_check("heater", fog_m[0] & hen_m[0], heat)
        `stc_check("irq", 1'((st_m & mask_m) != 0), irq)
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        void'($urandom(4440));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) rchk("threshold", A_THR_BASE + 6'(4 * i), th[i]);
        rchk("timer", A_TIMER, 32'h3840);
        rchk("heater enable", A_HEAT, 32'h1);
        rchk("mask", A_MASK, 32'h0);
        rw(6'h38, 32'hffffffff);
        rchk("unmapped", 6'h38, 32'h0);
        step(140, 120);
        step(141, 120);
        rw(A_MASK, 32'h1f);
        mask_m = 31;
        step(130, 130);
        step(129, 60);
        stchk();
        // Restart limit first, so the limits never cross while the sign is hot
        thr(1, 95);
        thr(0, 100);
        step(101, 50);
        step(96, 96);
        step(94, 94);
        thr(0, 140);
        thr(1, 130);
        thr(6, 50);
        step(45, 60);
        thr(6, 40);
        step(107, 60);
        step(90, 90);
        step(91, 80);
        step(85, 85);
        step(84, 84);
        step(39, 60);
        rw(A_HEAT, 32'h0);
        hen_m = 0;
        step(39, 60);
        rw(A_HEAT, 32'h1);
        hen_m = 1;
        step(106, 106);
        step(107, 50);
        pwr <= 1'b0;
        st_m |= 4;
        step(70, 70);
        rchk("state", A_STATE, state_m());
        stchk();
        pwr <= 1'b1;
        step(-50, 10);
        rchk("temps", A_TEMP, {16'h000a, 16'hffd8});
        step(300, 100);
        rchk("temps", A_TEMP, {16'h0064, 16'h00b9});
        // Range flag re-sets while a reading is out of range, so clear only once back inside
        step(60, 60);
        stchk();
        rw(A_TIMER, 32'h3);
        step(95, 95);
        repeat (10) @(posedge clk);
        `stc_check("early expiry", 1'b1, hfan)
        for (int n = 0; n < 40 && hfan !== 1'b0; n++) @(posedge clk);
        texp_m = 1;
        st_m |= 16;
        step(95, 95);
        rchk("state", A_STATE, state_m());
        step(80, 80);
        stchk();
        stc_host_inst.be_sel = 4'h2;
        rw(A_TIMER, 32'h0000_1200);
        stc_host_inst.be_sel = 4'hf;
        rchk("byte lane", A_TIMER, 32'h0000_1203);
        rw(A_TIMER, 32'h0);
        for (int i = 0; i < 200; i++) begin
            a = int'($urandom_range(250)) - 55;
            step(a, a + int'($urandom_range(16)) - 8);
            if (i % 16 == 15) begin
                step(60, 60);
                stchk();
            end
        end
        end_sim();
    end
endmodule
